// ==== elu_top.sv ====
// event link interrupt unit: routes events to cpu lines, transfer and dma requests,
// and gathers the non-maskable sources.
// assumes peripheral event inputs and fault inputs are on clk_sys; pins are asynchronous.
// Notes on behaviour
// - selected events are routed to cpu lines, transfer requests and dma requests, and non-maskable sources are gathered here.
// - peripheral sources are 480 event numbers 32 to 511, of which the device uses 223.
// - each external pin detects low level, falling edge, rising edge or both edges.
// - there are sixteen external pins, indexed 0 to 15.
// - each external pin has an optional digital filter ahead of detection.
// - ninety-six request lines go to the cpu interrupt controller, each with one selected source.
// - each dma channel picks its own triggering source.
// - the transfer controller is triggered through the same per-line selection.
// - the non-maskable pin detects a falling or a rising edge and has an optional filter.
// - both watchdogs raise a non-maskable event on underflow or refresh error.
// - each supply monitor raises its own non-maskable event.
// - an sram parity error raises a non-maskable event.
// - an sram ecc error raises a non-maskable event.
// - the filter passes a level only after three equal samples, adding that latency.
// - each pin picks its filter rate from the clock undivided or divided by 8, 32 or 64.
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "elu_cfg.svh"
module elu_top (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [9:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic [`ELU_NUM_PERIPH-1:0] periph_evt,
	input wire logic [`ELU_NUM_PINS-1:0] ext_irq_pin_n,
	input wire logic nmi_pin,
	input wire logic main_watchdog_underflow,
	input wire logic main_watchdog_refresh_err,
	input wire logic independent_watchdog_underflow,
	input wire logic independent_watchdog_refresh_err,
	input wire logic supply_monitor_one_irq,
	input wire logic supply_monitor_two_irq,
	input wire logic sram_parity_error_irq,
	input wire logic sram_ecc_error_irq,
	input wire logic [`ELU_NUM_LINES-1:0] cpu_irq_ack,
	input wire logic [`ELU_NUM_LINES-1:0] dtc_ack,
	input wire logic [`ELU_NUM_DMA-1:0] dma_ack,
	output logic [`ELU_NUM_LINES-1:0] cpu_irq,
	output logic [`ELU_NUM_LINES-1:0] dtc_req,
	output logic [`ELU_NUM_DMA-1:0] dma_req,
	output logic nmi_irq
);
	localparam int NF = `ELU_NUM_PINS + 1;

	// configuration storage
	logic [8:0] line_sel_q [`ELU_NUM_LINES];
	logic [`ELU_NUM_LINES-1:0] line_dtc_q;
	logic [4:0] pin_cfg_q [`ELU_NUM_PINS];
	logic [8:0] dma_sel_q [`ELU_NUM_DMA];
	logic [3:0] nmi_cfg_q;
	logic [6:0] nmi_stat_q;
	logic [6:0] nmi_mask_q;
	logic [`ELU_NUM_LINES-1:0] pend_q;
	logic [`ELU_NUM_LINES-1:0] pend_d;
	logic [`ELU_NUM_DMA-1:0] dma_pend_q;
	logic [`ELU_NUM_DMA-1:0] dma_pend_d;
	logic [`ELU_NUM_LINES-1:0] cpu_irq_q;
	logic [`ELU_NUM_LINES-1:0] dtc_req_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic nmi_irq_q;

	// pin synchronisers, filters and detection
	logic [NF-1:0] sync1_q;
	logic [NF-1:0] sync2_q;
	wire [NF-1:0] filt_q;
	wire [NF-1:0] filt_prev_q;
	logic [5:0] presc_q;
	logic [NF-1:0] tick;
	logic [`ELU_NUM_PINS-1:0] pin_evt;
	logic nmi_pin_evt;
	logic [511:0] evt_all;
	logic [6:0] nmi_src;
	logic [6:0] nmi_stat_d;

	// register decode
	wire line_hit = reg_addr < `ELU_LINE_END;
	wire pin_hit = (reg_addr >= `ELU_PIN_BASE) && (reg_addr < `ELU_PIN_END);
	wire dma_hit = (reg_addr >= `ELU_DMA_BASE) && (reg_addr < `ELU_DMA_END);
	wire [6:0] line_idx = reg_addr[8:2];
	wire [3:0] pin_idx = reg_addr[5:2];
	wire [2:0] dma_idx = reg_addr[4:2];
	wire wr_line = reg_wr && line_hit;
	wire wr_pin = reg_wr && pin_hit;
	wire wr_dma = reg_wr && dma_hit;
	wire wr_nmi_cfg = reg_wr && (reg_addr == `ELU_NMI_CFG);
	wire wr_nmi_stat = reg_wr && (reg_addr == `ELU_NMI_STAT);
	wire wr_nmi_mask = reg_wr && (reg_addr == `ELU_NMI_MASK);
	wire wr_pend0 = reg_wr && (reg_addr == `ELU_PEND0);
	wire wr_pend1 = reg_wr && (reg_addr == `ELU_PEND1);
	wire wr_pend2 = reg_wr && (reg_addr == `ELU_PEND2);
	wire [`ELU_NUM_LINES-1:0] sw_clr = {
		wr_pend2 ? reg_wdata : 32'h0000_0000,
		wr_pend1 ? reg_wdata : 32'h0000_0000,
		wr_pend0 ? reg_wdata : 32'h0000_0000};

	// filter sample ticks: one shared prescaler, tap chosen per pin
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			presc_q <= 6'h00;
		end else if (clk_en) begin
			presc_q <= presc_q + 6'h01;
		end
	end

	// one source per filter; index 16 is the non-maskable pin
	wire [NF-1:0] pin_raw = {nmi_pin, ext_irq_pin_n};

	// reset to the idle high level so no false edge follows reset
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sync1_q <= {NF{1'b1}};
			sync2_q <= {NF{1'b1}};
		end else if (clk_en) begin
			sync1_q <= pin_raw;
			sync2_q <= sync1_q;
		end
	end

	genvar gf;
	generate
		for (gf = 0; gf < NF; gf++) begin : g_filt
			logic [1:0] fclk;
			logic fen;
			logic [2:0] samp_q;
			logic filt_bit_q;
			logic prev_bit_q;
			// one process per bit keeps each flip-flop with a single driver
			assign filt_q[gf] = filt_bit_q;
			assign filt_prev_q[gf] = prev_bit_q;
			if (gf < `ELU_NUM_PINS) begin : g_pin
				assign fclk = pin_cfg_q[gf][4:3];
				assign fen = pin_cfg_q[gf][2];
			end else begin : g_nmi
				assign fclk = nmi_cfg_q[3:2];
				assign fen = nmi_cfg_q[`ELU_NMI_FEN_BIT];
			end
			assign tick[gf] = (fclk == elu_pkg::ELU_FCLK_DIV1) ? 1'b1 :
				(fclk == elu_pkg::ELU_FCLK_DIV8) ? (presc_q[2:0] == 3'h0) :
				(fclk == elu_pkg::ELU_FCLK_DIV32) ? (presc_q[4:0] == 5'h00) :
				(presc_q == 6'h00);
			// three equal samples move the output; shorter pulses never reach it
			always_ff @(posedge clk_sys) begin
				if (!rst_n) begin
					samp_q <= 3'h7;
					filt_bit_q <= 1'b1;
					prev_bit_q <= 1'b1;
				end else if (clk_en) begin
					prev_bit_q <= filt_bit_q;
					if (!fen) begin
						filt_bit_q <= sync2_q[gf];
					end else if (tick[gf]) begin
						samp_q <= {samp_q[1:0], sync2_q[gf]};
						if (samp_q == 3'h7) begin
							filt_bit_q <= 1'b1;
						end else if (samp_q == 3'h0) begin
							filt_bit_q <= 1'b0;
						end
					end
				end
			end
		end
	endgenerate

	// detection per external pin
	genvar gp;
	generate
		for (gp = 0; gp < `ELU_NUM_PINS; gp++) begin : g_det
			wire [1:0] mode = pin_cfg_q[gp][`ELU_MODE_LSB +: 2];
			wire rise = filt_q[gp] & ~filt_prev_q[gp];
			wire fall = ~filt_q[gp] & filt_prev_q[gp];
			assign pin_evt[gp] = (mode == elu_pkg::ELU_DET_LOW) ? ~filt_q[gp] :
				(mode == elu_pkg::ELU_DET_FALL) ? fall :
				(mode == elu_pkg::ELU_DET_RISE) ? rise :
				(rise | fall);
		end
	endgenerate

	// pin numbers are shared by both pin variants, so software keeps one enabled
	assign nmi_pin_evt = nmi_cfg_q[`ELU_NMI_RISE_BIT] ?
		(filt_q[NF-1] & ~filt_prev_q[NF-1]) :
		(~filt_q[NF-1] & filt_prev_q[NF-1]);

	// event number space: 0 none, 1..16 pins, 32..511 peripherals
	assign evt_all = {periph_evt, 15'h0000, pin_evt, 1'b0};

	// request lines: pending held until accepted or cleared, set beats clear
	genvar gl;
	generate
		for (gl = 0; gl < `ELU_NUM_LINES; gl++) begin : g_line
			wire hit = evt_all[line_sel_q[gl]];
			// only the consumer the line is routed to may retire it
			wire ack = line_dtc_q[gl] ? dtc_ack[gl] : cpu_irq_ack[gl];
			assign pend_d[gl] = hit | (pend_q[gl] & ~ack & ~sw_clr[gl]);
		end
		// no software clear here: a stuck dma request needs its acknowledge
		for (gl = 0; gl < `ELU_NUM_DMA; gl++) begin : g_dma
			wire hit = evt_all[dma_sel_q[gl]];
			assign dma_pend_d[gl] = hit | (dma_pend_q[gl] & ~dma_ack[gl]);
		end
	endgenerate

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pend_q <= '0;
			dma_pend_q <= '0;
			cpu_irq_q <= '0;
			dtc_req_q <= '0;
		end else if (clk_en) begin
			pend_q <= pend_d;
			dma_pend_q <= dma_pend_d;
			cpu_irq_q <= pend_d & ~line_dtc_q;
			dtc_req_q <= pend_d & line_dtc_q;
		end
	end

	// non-maskable sources: sticky, write one to clear, set beats clear
	wire main_wd_fault = main_watchdog_underflow | main_watchdog_refresh_err;
	wire indep_wd_fault = independent_watchdog_underflow | independent_watchdog_refresh_err;
	assign nmi_src = {sram_ecc_error_irq,
		sram_parity_error_irq,
		supply_monitor_two_irq, supply_monitor_one_irq,
		indep_wd_fault,
		main_wd_fault,
		nmi_pin_evt};
	// a fault still present during the clear keeps its bit set
	wire [6:0] nmi_w1c = wr_nmi_stat ? reg_wdata[6:0] : 7'h00;
	assign nmi_stat_d = nmi_src | (nmi_stat_q & ~nmi_w1c);
	wire nmi_irq_d = |(nmi_stat_d & nmi_mask_q);

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			nmi_stat_q <= '0;
			nmi_irq_q <= 1'b0;
		end else if (clk_en) begin
			nmi_stat_q <= nmi_stat_d;
			nmi_irq_q <= nmi_irq_d;
		end
	end

	// configuration writes
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			for (int i = 0; i < `ELU_NUM_LINES; i++) begin
				line_sel_q[i] <= `ELU_SEL_RST;
			end
			line_dtc_q <= '0;
		end else if (clk_en && wr_line) begin
			line_sel_q[line_idx] <= reg_wdata[`ELU_SEL_MSB:`ELU_SEL_LSB];
			line_dtc_q[line_idx] <= reg_wdata[`ELU_DTC_BIT];
		end
	end

	// pin cfg packs mode[1:0], filter enable[2], rate[4:3]
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			for (int i = 0; i < `ELU_NUM_PINS; i++) begin
				pin_cfg_q[i] <= `ELU_PIN_CFG_RST;
			end
		end else if (clk_en && wr_pin) begin
			pin_cfg_q[pin_idx] <= {reg_wdata[`ELU_FCLK_LSB +: 2], reg_wdata[`ELU_FEN_BIT],
				reg_wdata[`ELU_MODE_LSB +: 2]};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			for (int i = 0; i < `ELU_NUM_DMA; i++) begin
				dma_sel_q[i] <= `ELU_SEL_RST;
			end
		end else if (clk_en && wr_dma) begin
			dma_sel_q[dma_idx] <= reg_wdata[`ELU_SEL_MSB:`ELU_SEL_LSB];
		end
	end

	// nmi cfg packs rising[0], filter enable[1], rate[3:2]
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			nmi_cfg_q <= `ELU_NMI_CFG_RST;
			nmi_mask_q <= `ELU_MASK_RST;
		end else if (clk_en) begin
			if (wr_nmi_cfg) begin
				nmi_cfg_q <= {reg_wdata[`ELU_FCLK_LSB +: 2], reg_wdata[1:0]};
			end
			if (wr_nmi_mask) begin
				nmi_mask_q <= reg_wdata[6:0];
			end
		end
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (line_hit) begin
			rdata_d[`ELU_SEL_MSB:`ELU_SEL_LSB] = line_sel_q[line_idx];
			rdata_d[`ELU_DTC_BIT] = line_dtc_q[line_idx];
		end else if (pin_hit) begin
			rdata_d[`ELU_MODE_LSB +: 2] = pin_cfg_q[pin_idx][1:0];
			rdata_d[`ELU_FEN_BIT] = pin_cfg_q[pin_idx][2];
			rdata_d[`ELU_FCLK_LSB +: 2] = pin_cfg_q[pin_idx][4:3];
		end else if (dma_hit) begin
			rdata_d[`ELU_SEL_MSB:`ELU_SEL_LSB] = dma_sel_q[dma_idx];
		end else begin
			case (reg_addr)
				`ELU_NMI_CFG: begin
					rdata_d[1:0] = nmi_cfg_q[1:0];
					rdata_d[`ELU_FCLK_LSB +: 2] = nmi_cfg_q[3:2];
				end
				`ELU_NMI_STAT: rdata_d[6:0] = nmi_stat_q;
				`ELU_NMI_MASK: rdata_d[6:0] = nmi_mask_q;
				`ELU_PEND0: rdata_d = pend_q[31:0];
				`ELU_PEND1: rdata_d = pend_q[63:32];
				`ELU_PEND2: rdata_d = pend_q[95:64];
				`ELU_PIN_LVL: rdata_d[16:0] = filt_q;
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rdata_q <= 32'h0000_0000;
		end else if (clk_en) begin
			rdata_q <= reg_rd ? rdata_d : 32'h0000_0000;
		end
	end

	assign reg_rdata = rdata_q;
	assign cpu_irq = cpu_irq_q;
	assign dtc_req = dtc_req_q;
	assign dma_req = dma_pend_q;
	assign nmi_irq = nmi_irq_q;
endmodule

// ==== elu_cfg.svh ====
// event link interrupt unit: register offsets, field positions, reset values, counts
// assumes byte addresses on a 10-bit register port, one word per register
`ifndef ELU_CFG_SVH
`define ELU_CFG_SVH
`define ELU_NUM_LINES 96
`define ELU_NUM_PINS 16
`define ELU_NUM_DMA 8
`define ELU_NUM_PERIPH 480
`define ELU_PERIPH_FIRST 32
`define ELU_PIN_EVT_FIRST 1
`define ELU_FILT_SAMPLES 3
`define ELU_DIV_A 8
`define ELU_DIV_B 32
`define ELU_DIV_C 64
`define ELU_LINE_BASE 10'h000
`define ELU_LINE_END 10'h180
`define ELU_PIN_BASE 10'h200
`define ELU_PIN_END 10'h240
`define ELU_DMA_BASE 10'h280
`define ELU_DMA_END 10'h2a0
`define ELU_NMI_CFG 10'h300
`define ELU_NMI_STAT 10'h304
`define ELU_NMI_MASK 10'h308
`define ELU_PEND0 10'h310
`define ELU_PEND1 10'h314
`define ELU_PEND2 10'h318
`define ELU_PIN_LVL 10'h320
`define ELU_SEL_LSB 0
`define ELU_SEL_MSB 8
`define ELU_DTC_BIT 16
`define ELU_MODE_LSB 0
`define ELU_FEN_BIT 4
`define ELU_FCLK_LSB 8
`define ELU_NMI_RISE_BIT 0
`define ELU_NMI_FEN_BIT 1
`define ELU_NMI_SRC 7
`define ELU_SEL_RST 9'h000
`define ELU_PIN_CFG_RST 5'h00
`define ELU_NMI_CFG_RST 4'h0
`define ELU_MASK_RST 7'h00
`endif

// ==== elu_pkg.sv ====
// event link interrupt unit: shared types
// constants live in elu_cfg.svh
package elu_pkg;
	typedef enum logic [1:0] {
		ELU_DET_LOW = 2'h0,
		ELU_DET_FALL = 2'h1,
		ELU_DET_RISE = 2'h2,
		ELU_DET_BOTH = 2'h3
	} elu_det_e;
	typedef enum logic [1:0] {
		ELU_FCLK_DIV1 = 2'h0,
		ELU_FCLK_DIV8 = 2'h1,
		ELU_FCLK_DIV32 = 2'h2,
		ELU_FCLK_DIV64 = 2'h3
	} elu_fclk_e;
endpackage

// ==== elu_top_chk.sv ====
// checker for elu_top: port-level relations of the event link interrupt unit
// assumes it is bound into elu_top and sees only its ports
`timescale 1ns/1ps
module elu_top_chk (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [9:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic main_watchdog_underflow,
	input wire logic main_watchdog_refresh_err,
	input wire logic independent_watchdog_underflow,
	input wire logic independent_watchdog_refresh_err,
	input wire logic supply_monitor_one_irq,
	input wire logic supply_monitor_two_irq,
	input wire logic sram_parity_error_irq,
	input wire logic sram_ecc_error_irq,
	input wire logic [95:0] cpu_irq_ack,
	input wire logic [7:0] dma_ack,
	input wire logic [95:0] cpu_irq,
	input wire logic [95:0] dtc_req,
	input wire logic [7:0] dma_req,
	input wire logic nmi_irq
);
	logic [6:0] mask_q;
	wire logic wdt = main_watchdog_underflow | main_watchdog_refresh_err;
	wire logic independent_watchdog = independent_watchdog_underflow | independent_watchdog_refresh_err;
	wire logic [3:0] other = {sram_ecc_error_irq, sram_parity_error_irq,
		supply_monitor_two_irq, supply_monitor_one_irq};
	// shadow of the nmi mask, so fault checks know which sources may raise nmi_irq
	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			mask_q <= 7'h00;
		else if (clk_en && reg_wr && reg_addr == 10'h308)
			mask_q <= reg_wdata[6:0];
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	chk_rdata_idle: assert property ($past(clk_en) && !$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data not zero outside read slot");
	chk_route_excl: assert property ((cpu_irq & dtc_req) == 96'h0)
		else $error("line raised to cpu and transfer at once");
	chk_line_hold: assert property (!(clk_en && reg_wr)
		|=> ($past(cpu_irq & ~(clk_en ? cpu_irq_ack : 96'h0)) & ~cpu_irq) == 96'h0)
		else $error("cpu line dropped without ack");
	chk_dma_hold: assert property (!(clk_en && reg_wr)
		|=> ($past(dma_req & ~(clk_en ? dma_ack : 8'h0)) & ~dma_req) == 8'h0)
		else $error("dma request dropped without ack");
	chk_wdt_nmi: assert property (clk_en && !reg_wr && (wdt && mask_q[1] || independent_watchdog && mask_q[2])
		|=> nmi_irq)
		else $error("watchdog fault did not raise nmi");
	chk_fault_nmi: assert property (clk_en && !reg_wr && |(other & mask_q[6:3]) |=> nmi_irq)
		else $error("monitor or sram fault did not raise nmi");
	chk_nmi_masked: assert property ($past(mask_q) == 7'h0 && mask_q == 7'h0 |-> !nmi_irq)
		else $error("nmi raised with mask clear");
	chk_nmi_fall: assert property ($fell(nmi_irq) |-> $past(reg_wr)
		&& ($past(reg_addr) == 10'h304 || $past(reg_addr) == 10'h308))
		else $error("nmi dropped without status or mask write");
	cover property ($rose(cpu_irq[2]));
	cover property ($rose(dma_req[7]));
	cover property ($rose(nmi_irq));
endmodule
bind elu_top elu_top_chk u_elu_top_chk (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .main_watchdog_underflow(main_watchdog_underflow),
	.main_watchdog_refresh_err(main_watchdog_refresh_err),
	.independent_watchdog_underflow(independent_watchdog_underflow),
	.independent_watchdog_refresh_err(independent_watchdog_refresh_err),
	.supply_monitor_one_irq(supply_monitor_one_irq),
	.supply_monitor_two_irq(supply_monitor_two_irq),
	.sram_parity_error_irq(sram_parity_error_irq), .sram_ecc_error_irq(sram_ecc_error_irq),
	.cpu_irq_ack(cpu_irq_ack), .dma_ack(dma_ack), .cpu_irq(cpu_irq), .dtc_req(dtc_req),
	.dma_req(dma_req), .nmi_irq(nmi_irq));

// ==== elu_consumer.sv ====
// partner model: a request consumer that acknowledges pending lines
// assumes req is a registered level on clk_sys; ack is a one-cycle pulse
`timescale 1ns/1ps
module elu_consumer #(parameter int N = 8) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic en,
	input wire logic [3:0] dly,
	input wire logic [N-1:0] req,
	output logic [N-1:0] ack
);
	logic [3:0] cnt_q;
	wire logic busy = |(req & ~ack);
	// en low stalls the consumer, so the unit must keep its requests pending
	always_ff @(posedge clk_sys) begin
		if (!rst_n || !busy) begin
			cnt_q <= 4'h0;
			ack <= '0;
		end else if (en && cnt_q >= dly) begin
			cnt_q <= 4'h0;
			ack <= req;
		end else begin
			cnt_q <= cnt_q + {3'h0, en};
			ack <= '0;
		end
	end
endmodule

// ==== tb_event_link_interrupt_unit.sv ====
// testbench for the event link interrupt unit: register, event, pin and fault scenarios
// assumes elu_top, elu_consumer and the bound checker are compiled alongside
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
	$display("mismatch %s expected %h seen %h", n, e, g); end end
module tb_event_link_interrupt_unit;
	logic clk_sys = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, nmi_pin = 1'b1, en = 1'b0;
	logic ce = 1'b1;
	logic [3:0] dly_cpu = 4'h2, dly_dtc = 4'h0, dly_dma = 4'h5;
	logic [9:0] reg_addr = 10'h000;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic [479:0] periph_evt = '0;
	logic [15:0] pin_n = 16'hffff;
	logic [7:0] flt = 8'h00, dma_req, dma_ack;
	logic [95:0] cpu_irq, dtc_req, cpu_ack, dtc_ack;
	logic nmi_irq;
	int mismatches = 0, samples_checked = 0;
	initial forever #2 clk_sys = ~clk_sys;
	elu_top u_elu_top (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(ce), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.periph_evt(periph_evt), .ext_irq_pin_n(pin_n), .nmi_pin(nmi_pin),
		.main_watchdog_underflow(flt[0]), .main_watchdog_refresh_err(flt[1]),
		.independent_watchdog_underflow(flt[2]), .independent_watchdog_refresh_err(flt[3]),
		.supply_monitor_one_irq(flt[4]), .supply_monitor_two_irq(flt[5]),
		.sram_parity_error_irq(flt[6]), .sram_ecc_error_irq(flt[7]), .cpu_irq_ack(cpu_ack),
		.dtc_ack(dtc_ack), .dma_ack(dma_ack), .cpu_irq(cpu_irq), .dtc_req(dtc_req),
		.dma_req(dma_req), .nmi_irq(nmi_irq));
	elu_consumer #(.N(96)) u_elu_consumer_cpu (.clk_sys(clk_sys), .rst_n(rst_n), .en(en),
		.dly(dly_cpu), .req(cpu_irq), .ack(cpu_ack));
	elu_consumer #(.N(96)) u_elu_consumer_dtc (.clk_sys(clk_sys), .rst_n(rst_n), .en(en),
		.dly(dly_dtc), .req(dtc_req), .ack(dtc_ack));
	elu_consumer #(.N(8)) u_elu_consumer_dma (.clk_sys(clk_sys), .rst_n(rst_n), .en(en),
		.dly(dly_dma), .req(dma_req), .ack(dma_ack));
	task automatic settle(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [9:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 `CHK("reg_rdata", e, reg_rdata)
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// generous bound: the sequence needs well under 2000 cycles
	initial begin
		#40000;
		mismatches++;
		stop_test;
	end
	initial begin
		int m;
		settle(8);
		rst_n <= 1'b1;
		rd(10'h000, 32'h0);
		rd(10'h200, 32'h0);
		rd(10'h3fc, 32'h0);
		wr(10'h17c, 32'h101ff);
		rd(10'h17c, 32'h101ff);
		wr(10'h004, 32'h25);
		wr(10'h29c, 32'h28);
		periph_evt[5] <= 1'b1;
		periph_evt[8] <= 1'b1;
		periph_evt[479] <= 1'b1;
		settle(1);
		periph_evt <= '0;
		settle(6);
		`CHK("cpu_irq", 96'h2, cpu_irq)
		`CHK("dtc_req", 96'h1 << 95, dtc_req)
		`CHK("dma_req", 8'h80, dma_req)
		rd(10'h310, 32'h2);
		ce <= 1'b0;
		en <= 1'b1;
		settle(12);
		`CHK("frozen cpu_irq", 96'h2, cpu_irq)
		ce <= 1'b1;
		settle(12);
		`CHK("acked lines", 96'h0, cpu_irq | dtc_req | {88'h0, dma_req})
		en <= 1'b0;
		wr(10'h008, 32'h4);
		for (m = 0; m < 4; m++) begin
			wr(10'h20c, 32'(m));
			wr(10'h310, 32'h4);
			pin_n[3] <= 1'b0;
			settle(8);
			`CHK("pin low", m != 2, cpu_irq[2])
			wr(10'h310, 32'h4);
			pin_n[3] <= 1'b1;
			settle(8);
			`CHK("pin high", m != 1, cpu_irq[2])
			wr(10'h310, 32'h4);
			settle(2);
			`CHK("pin cleared", 1'b0, cpu_irq[2])
		end
		wr(10'h00c, 32'h5);
		wr(10'h210, 32'h111);
		pin_n[4] <= 1'b0;
		settle(6);
		pin_n[4] <= 1'b1;
		settle(40);
		`CHK("short pulse", 1'b0, cpu_irq[3])
		pin_n[4] <= 1'b0;
		settle(10);
		`CHK("filter latency", 1'b0, cpu_irq[3])
		settle(40);
		`CHK("filtered fall", 1'b1, cpu_irq[3])
		rd(10'h320, 32'h1ffef);
		wr(10'h308, 32'h7f);
		for (m = 0; m < 8; m++) begin
			flt <= 8'h01 << m;
			settle(1);
			flt <= 8'h00;
			settle(1);
			`CHK("nmi_irq", 1'b1, nmi_irq)
			rd(10'h304, 32'h1 << (m < 4 ? 1 + m / 2 : m - 1));
			wr(10'h304, 32'h7f);
			settle(1);
			`CHK("nmi cleared", 1'b0, nmi_irq)
		end
		wr(10'h308, 32'h0);
		flt <= 8'hff;
		settle(2);
		flt <= 8'h00;
		`CHK("masked nmi", 1'b0, nmi_irq)
		rd(10'h304, 32'h7e);
		wr(10'h304, 32'h7f);
		wr(10'h308, 32'h1);
		nmi_pin <= 1'b0;
		settle(8);
		`CHK("nmi pin", 1'b1, nmi_irq)
		stop_test;
	end
endmodule
